// ===== tdct_params.svh
// Constants for the triple down-count timer: register indices, fields, resets.
// Assumes inclusion by bare name from the package and the timer module.
`ifndef TDCT_PARAMS_SVH
`define TDCT_PARAMS_SVH

// Register indices; the byte address is four times the index
`define TDCT_IDX_T0_CFG   8'hb0
`define TDCT_IDX_T0_HIGH  8'hb1
`define TDCT_IDX_T0_LOW   8'hb2
`define TDCT_IDX_T1_CFG   8'hb3
`define TDCT_IDX_T1_HIGH  8'hb4
`define TDCT_IDX_T1_LOW   8'hb5
`define TDCT_IDX_T2_CFG   8'hb6
`define TDCT_IDX_T2_HIGH  8'hb7
`define TDCT_IDX_T2_LOW   8'hb8
`define TDCT_IDX_LAST     8'hb8

// Configuration fields
`define TDCT_BIT_START    0
`define TDCT_BIT_ONESHOT  1
`define TDCT_BIT_CLOCK_SOURCE_SELECT   2
`define TDCT_CFG_W        3

// Reset values
`define TDCT_CFG_RST      3'h0
`define TDCT_DATA_RST     8'h00
`define TDCT_CNT_RST      16'h0000

`endif

// ===== tdct_pkg.sv
// Types shared by the triple down-count timer.
// Assumes tdct_params.svh sits in the same folder.
`default_nettype none
`include "tdct_params.svh"

package tdct_pkg;
	// Register kind within one timer's group of three
	typedef enum logic [1:0] {
		TDCT_KIND_CFG  = 2'b00,
		TDCT_KIND_HIGH = 2'b01,
		TDCT_KIND_LOW  = 2'b10
	} tdct_kind_e;

	// Bus slave phase
	typedef enum logic [0:0] {
		TDCT_BUS_IDLE = 1'b0,
		TDCT_BUS_RDWT = 1'b1
	} tdct_bus_e;

	typedef logic [15:0] tdct_cnt_t;
	typedef logic [`TDCT_CFG_W-1:0] tdct_cfg_t;
endpackage

`default_nettype wire

// ===== tdct_timer.sv
// Three 16-bit down-count timers behind an AHB-Lite slave.
// Assumes count ticks arrive as one-cycle strobes synchronous to clk.
//
// Design decision made here: the AHB-Lite interface to the registers.
`default_nettype none
`include "tdct_params.svh"

////////////////////////////////////////////////////////////////////////////////
module tdct_timer
	import tdct_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Count tick strobes
	input  wire logic        tick_32k,
	input  wire logic        prescaled_main_oscillator_clock,
	// Sensing and sleep control
	input  wire logic        capacitive_sense_mode,
	input  wire logic        sleep_wake_mode,
	// Timer outputs
	output logic             terminal_count_pulse,
	output logic             sense_start_strobe
);

	////////////////////////////////////////////////////////////////////////
	// Decode a byte address into {valid, timer, kind}
	function automatic logic [4:0] reg_decode(input logic [31:0] addr);
		logic [7:0] off;
		off = addr[9:2] - `TDCT_IDX_T0_CFG;
		reg_decode = 5'h00;
		if (addr[31:10] == 22'h000000 && addr[1:0] == 2'h0
		    && addr[9:2] >= `TDCT_IDX_T0_CFG && addr[9:2] <= `TDCT_IDX_LAST) begin
			case (off)
				8'h00, 8'h01, 8'h02: reg_decode = {3'b100, off[1:0]};
				8'h03, 8'h04, 8'h05: reg_decode = {3'b101, 2'(off - 8'h03)};
				default:             reg_decode = {3'b110, 2'(off - 8'h06)};
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus state
	tdct_bus_e   bus_q, bus_d;
	logic [4:0]  sel_q, sel_d;
	logic        wr_q, wr_d;
	logic [31:0] rdata_q, rdata_d;
	logic        accept;

	// Timer state
	tdct_cfg_t   cfg_q [3];
	tdct_cfg_t   cfg_d [3];
	logic [7:0]  hi_q [3];
	logic [7:0]  hi_d [3];
	logic [7:0]  lo_q [3];
	logic [7:0]  lo_d [3];
	tdct_cnt_t   cnt_q [3];
	tdct_cnt_t   cnt_d [3];
	logic [2:0]  hold_q, hold_d;
	logic [2:0]  tick, run, wrap, wr_hit;
	logic        tc_q, tc_d;
	logic        strobe_q, strobe_d;

	////////////////////////////////////////////////////////////////////////
	// Bus next state: reads take one wait state, writes none
	always_comb begin
		accept  = hsel & htrans[1] & hready;
		bus_d   = TDCT_BUS_IDLE;
		sel_d   = sel_q;
		wr_d    = 1'b0;
		rdata_d = rdata_q;
		case (bus_q)
			TDCT_BUS_RDWT: begin
				rdata_d = 32'h00000000;
				if (sel_q[4]) begin
					case (sel_q[1:0])
						TDCT_KIND_CFG:  rdata_d = {29'h0, cfg_q[sel_q[3:2]]};
						TDCT_KIND_HIGH: rdata_d = {24'h0, hi_q[sel_q[3:2]]};
						default:        rdata_d = {24'h0, lo_q[sel_q[3:2]]};
					endcase
				end
			end
			default: begin
				if (accept) begin
					sel_d = reg_decode(haddr);
					wr_d  = hwrite;
					if (!hwrite)
						bus_d = TDCT_BUS_RDWT;
				end
			end
		endcase
	end

	// Bus registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			bus_q   <= TDCT_BUS_IDLE;
			sel_q   <= 5'h00;
			wr_q    <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			bus_q   <= bus_d;
			sel_q   <= sel_d;
			wr_q    <= wr_d;
			rdata_q <= rdata_d;
		end
	end

	// Bus answers; unmapped reads give zero, always OKAY
	assign hreadyout = (bus_q == TDCT_BUS_IDLE);
	assign hresp     = 1'b0;
	assign hrdata    = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// One down counter per timer
	generate
		for (genvar i = 0; i < 3; i++) begin : g_tmr
			// Tick select and write hit
			always_comb begin
				if (i == 1 && capacitive_sense_mode)
					tick[i] = prescaled_main_oscillator_clock;
				else if (cfg_q[i][`TDCT_BIT_CLOCK_SOURCE_SELECT])
					tick[i] = 1'b1;
				else
					tick[i] = tick_32k;
				run[i]    = cfg_q[i][`TDCT_BIT_START] & ~hold_q[i];
				wrap[i]   = run[i] & tick[i] & (cnt_q[i] == 16'h0000);
				wr_hit[i] = wr_q & sel_q[4] & (sel_q[3:2] == 2'(i));
			end

			// Counter next state
			always_comb begin
				cfg_d[i]  = cfg_q[i];
				hi_d[i]   = hi_q[i];
				lo_d[i]   = lo_q[i];
				cnt_d[i]  = cnt_q[i];
				hold_d[i] = hold_q[i];
				if (wrap[i]) begin
					if (!cfg_q[i][`TDCT_BIT_ONESHOT])
						cnt_d[i] = {hi_q[i], lo_q[i]};
					else if (i == 0 && sleep_wake_mode)
						hold_d[i] = 1'b1;
					else
						cfg_d[i][`TDCT_BIT_START] = 1'b0;
				end else if (run[i] && tick[i]) begin
					cnt_d[i] = cnt_q[i] - 16'h0001;
				end
				// Software write wins over the hardware clear
				if (wr_hit[i]) begin
					case (sel_q[1:0])
						TDCT_KIND_CFG: begin
							cfg_d[i]  = hwdata[`TDCT_CFG_W-1:0];
							hold_d[i] = 1'b0;
							if (hwdata[`TDCT_BIT_START])
								cnt_d[i] = {hi_q[i], lo_q[i]};
						end
						TDCT_KIND_HIGH: hi_d[i] = hwdata[7:0];
						default:        lo_d[i] = hwdata[7:0];
					endcase
				end
			end

			// Counter registers
			always_ff @(posedge clk or negedge rstn) begin
				if (!rstn) begin
					cfg_q[i]  <= `TDCT_CFG_RST;
					hi_q[i]   <= `TDCT_DATA_RST;
					lo_q[i]   <= `TDCT_DATA_RST;
					cnt_q[i]  <= `TDCT_CNT_RST;
					hold_q[i] <= 1'b0;
				end else begin
					cfg_q[i]  <= cfg_d[i];
					hi_q[i]   <= hi_d[i];
					lo_q[i]   <= lo_d[i];
					cnt_q[i]  <= cnt_d[i];
					hold_q[i] <= hold_d[i];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Terminal count of timer zero and the sensing strobe
	always_comb begin
		tc_d     = cfg_d[0][`TDCT_BIT_START] & ~hold_d[0]
		           & (cnt_d[0] == 16'h0000);
		strobe_d = wrap[1] & capacitive_sense_mode;
	end

	// Output registers
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tc_q     <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			tc_q     <= tc_d;
			strobe_q <= strobe_d;
		end
	end

	assign terminal_count_pulse = tc_q;
	assign sense_start_strobe   = strobe_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	decrement_step_a: assert property (
		run[2] && tick[2] && cnt_q[2] != 16'h0000 && !wr_hit[2]
		|=> cnt_q[2] == $past(cnt_q[2]) - 16'h0001)
		else $error("count did not step down by one");

	oneshot_stop_a: assert property (
		wrap[0] && cfg_q[0][`TDCT_BIT_ONESHOT] && !sleep_wake_mode && !wr_hit[0]
		|=> !cfg_q[0][`TDCT_BIT_START] && !terminal_count_pulse)
		else $error("one-shot timer did not stop");

	reload_cont_a: assert property (
		wrap[1] && !cfg_q[1][`TDCT_BIT_ONESHOT] && !wr_hit[1]
		|=> cnt_q[1] == {hi_q[1], lo_q[1]} && cfg_q[1][`TDCT_BIT_START])
		else $error("continuous timer did not reload");

	start_load_a: assert property (
		wr_hit[0] && sel_q[1:0] == TDCT_KIND_CFG && hwdata[`TDCT_BIT_START]
		|=> cnt_q[0] == {$past(hi_q[0]), $past(lo_q[0])} && run[0])
		else $error("start did not load full count");

	tc_width_a: assert property (
		tc_q && cfg_q[0][`TDCT_BIT_CLOCK_SOURCE_SELECT] && {hi_q[0], lo_q[0]} != 16'h0000
		&& !wr_hit[0] |=> !tc_q)
		else $error("terminal count wider than one tick");

	tc_source_a: assert property (
		terminal_count_pulse |-> cnt_q[0] == 16'h0000 && run[0])
		else $error("terminal count without timer zero at zero");

	slow_clock_a: assert property (
		!cfg_q[0][`TDCT_BIT_CLOCK_SOURCE_SELECT] && !tick_32k && !wr_hit[0]
		|=> $stable(cnt_q[0]))
		else $error("32k timer moved without a tick");

	sense_clock_a: assert property (
		capacitive_sense_mode && !prescaled_main_oscillator_clock && !wr_hit[1]
		|=> $stable(cnt_q[1]))
		else $error("timer one moved without a prescaled tick");

	sense_strobe_a: assert property (
		sense_start_strobe |-> $past(wrap[1]) && $past(capacitive_sense_mode))
		else $error("strobe without timer one wrap");

	sleep_hold_a: assert property (
		wrap[0] && cfg_q[0][`TDCT_BIT_ONESHOT] && sleep_wake_mode && !wr_hit[0]
		|=> cfg_q[0][`TDCT_BIT_START] && !run[0] ##1 $stable(cnt_q[0]) || wr_hit[0])
		else $error("sleep one-shot lost its start bit");

	data_quiet_a: assert property (
		wr_hit[2] && sel_q[1:0] != TDCT_KIND_CFG && !tick[2]
		|=> $stable(cnt_q[2]))
		else $error("data write disturbed the count");

	read_wait_a: assert property (
		accept && !hwrite && hreadyout |=> !hreadyout ##1 hreadyout)
		else $error("read did not take one wait state");

	// Terminal count rises as the count steps onto zero
	tc_rise_a: assert property (
		run[0] && tick[0] && cnt_q[0] == 16'h0001 && !wr_hit[0]
		|=> terminal_count_pulse)
		else $error("terminal count missed its zero");

	// Every timer one wrap in sense mode gives a strobe
	sense_wrap_a: assert property (
		wrap[1] && capacitive_sense_mode |=> sense_start_strobe)
		else $error("timer one wrap without strobe");

	cover_oneshot_c: cover property (wrap[0] && cfg_q[0][`TDCT_BIT_ONESHOT]);
	cover_reload_c:  cover property (wrap[0] ##[1:40] wrap[0]);
	cover_strobe_c:  cover property (sense_start_strobe);
	cover_setclr_c:  cover property (wrap[2] && wr_hit[2]);

endmodule

`default_nettype wire

// ===== triple_down_count_timer_test.sv
// Self-checking bench for the triple down-count timer over AHB-Lite.
// Assumes tdct_pkg and tdct_params.svh are compiled beside it.
`default_nettype none
`include "tdct_params.svh"

module triple_down_count_timer_test
	import tdct_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic        clk, rstn, hsel, hwrite, sense, sleep, hreadyout, hresp, tc, ss;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        tick_32k = 1'b0;
	logic        pmo      = 1'b0;
	logic        rd_ph    = 1'b0;
	logic [7:0]  tcnt     = 8'h00;
	logic [31:0] exp_q[$];
	int          bad_count, checked, n;
	int          seed     = 32'hd565ca6b;

	////////////////////////////////////////////////////////////////////////////
	// Device under test, bus ready looped back
	tdct_timer tdct_timer_inst (
		.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.tick_32k(tick_32k), .prescaled_main_oscillator_clock(pmo),
		.capacitive_sense_mode(sense), .sleep_wake_mode(sleep),
		.terminal_count_pulse(tc), .sense_start_strobe(ss)
	);

	// Clock, 40 ns period
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Tick strobes: slow tick every 8 clocks, prescaled every 4
	always @(posedge clk) begin
		tcnt     <= tcnt + 8'h01;
		tick_32k <= (tcnt[2:0] == 3'h7);
		pmo      <= (tcnt[1:0] == 2'h3);
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparison and closing
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	// Read monitor: compares data at the completing data phase
	always @(negedge clk) begin
		if (rd_ph && hreadyout) begin
			check(hrdata, exp_q.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
		if (hreadyout)
			rd_ph = hsel && htrans[1] && !hwrite;
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus master tasks, single word transfers
	function automatic logic [7:0] ix(input int t, input int k);
		return 8'(`TDCT_IDX_T0_CFG + 3 * t + k);
	endfunction

	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		haddr  <= {22'h0, a, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		do @(negedge clk); while (hreadyout !== 1'b1);
		@(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		do @(negedge clk); while (hreadyout !== 1'b1);
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		bus(a, 1'b1, {24'h0, d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(a, 1'b0, 32'h0);
	endtask

	task automatic load(input int t, input logic [15:0] v);
		wr(ix(t, 1), v[15:8]);
		wr(ix(t, 2), v[7:0]);
	endtask

	function automatic logic sig(input bit s);
		return s ? ss : tc;
	endfunction

	// Rise-to-rise period and high width of a timer output
	task automatic gap(input bit s, input int e, input int w);
		int m;
		int h;
		m = 0;
		h = 0;
		@(negedge clk);
		while (sig(s) && m < 9000) begin @(negedge clk); m++; end
		while (!sig(s) && m < 9000) begin @(negedge clk); m++; end
		m = 0;
		while (sig(s) && m < 9000) begin @(negedge clk); m++; h++; end
		while (!sig(s) && m < 9000) begin @(negedge clk); m++; end
		check(32'(h), 32'(w));
		check(32'(m), 32'(e));
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rstn, hsel, hwrite, sense, sleep} = '0;
		htrans = 2'b00;
		haddr  = '0;
		hwdata = '0;
		hsize  = 3'b010;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		hsel <= 1'b1;
		for (int t = 0; t < 3; t++) begin
			rd(ix(t, 0), 32'h0);
			n = $random(seed);
			load(t, n[15:0]);
			rd(ix(t, 1), {24'h0, n[15:8]});
			rd(ix(t, 2), {24'h0, n[7:0]});
		end
		rd(8'hb9, 32'h0);
		done("registers");
		n = ($random(seed) & 3) + 1;
		load(0, n[15:0]);
		wr(ix(0, 0), 8'h05);
		gap(0, n + 1, 1);
		wr(ix(0, 0), 8'h01);
		gap(0, 8 * (n + 1), 8);
		done("continuous");
		wr(ix(0, 0), 8'h07);
		repeat (n + 3) @(posedge clk);
		rd(ix(0, 0), 32'h6);
		load(0, 16'h0100);
		wr(ix(0, 0), 8'h07);
		rd(ix(0, 0), 32'h7);
		sleep <= 1'b1;
		load(0, n[15:0]);
		wr(ix(0, 0), 8'h07);
		repeat (n + 3) @(posedge clk);
		rd(ix(0, 0), 32'h7);
		sleep <= 1'b0;
		wr(ix(0, 0), 8'h00);
		done("one_shot");
		// Park timer zero on a nonzero count
		load(0, 16'h1234);
		wr(ix(0, 0), 8'h05);
		wr(ix(0, 0), 8'h00);
		sense <= 1'b1;
		load(2, 16'h0002);
		wr(ix(2, 0), 8'h05);
		load(1, n[15:0]);
		wr(ix(1, 0), 8'h01);
		gap(1, 4 * (n + 1), 1);
		repeat (12) begin
			@(negedge clk);
			check({31'h0, tc}, 32'h0);
		end
		done("sense");
		results();
	end

	// Watchdog
	initial begin
		#400us;
		bad_count++;
		$display("mismatch at %0t: watchdog got %h expected %h", $time, 0, 1);
		results();
	end
endmodule

`default_nettype wire
